// [verilog/serial_host_port_image_boot.sv]
// serial host port with image loading, reporting and clock divider control
`timescale 1ns/1ns
module serial_host_port_image_boot #(
    parameter int          LATENCY_CYCLES  = host_port_pkg::LATENCY_CYCLES,
    parameter logic [15:0] PRODUCT_ID      = 16'h0a5c,  // arbitrary value
    parameter logic [15:0] ACTIVATION_CODE = 16'h3c96   // arbitrary value
) (
    // clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // serial host pins
    input  wire logic        chipSelectLow,
    input  wire logic        serialClock,
    input  wire logic        commandSerialIn,
    output logic             replyData,
    output logic             replyDataOe,
    // open-drain interrupt pin
    input  wire logic        hostInterruptLowIn,
    output logic             hostInterruptLowOut,
    output logic             hostInterruptLowOe,
    // boot source strap pins
    input  wire logic [1:0]  bootSourceSelect,
    // device side
    output logic             rxActive,
    output logic             txActive,
    output logic             imageActive,
    output logic [11:0]      refDivide,
    output logic [11:0]      loopDivide,
    output logic [11:0]      auxDivide,
    output logic [11:0]      adcDivide
);
    localparam int AW = $clog2(host_port_pkg::IMAGE_WORDS);
    localparam int LW = $clog2(LATENCY_CYCLES);
    localparam logic [AW:0]   PTR_FULL = (AW+1)'(host_port_pkg::IMAGE_WORDS);
    localparam logic [LW-1:0] TICK_LAST = LW'(LATENCY_CYCLES - 1);
    localparam logic [1:0]    SETTLE_LAST = 2'(host_port_pkg::BOOT_SETTLE_CYCLES - 1);

    typedef struct packed {
        host_port_pkg::boot_state_t state;
        logic [1:0]    settle;
        logic          csPrev;
        logic          sclkPrev;
        logic [2:0]    bitCnt;
        logic [1:0]    byteCnt;
        logic          inData;
        logic          isRead;
        logic [1:0]    nBytes;
        logic [7:0]    addr;
        logic [15:0]   rxShift;
        logic [15:0]   txShift;
        logic          txPend;
        logic          replyBit;
        logic          replyOe;
        logic          irqOut;
        logic          irqOe;
        logic [15:0]   mask;
        logic [1:0]    events;
        logic          ready;
        logic          imageValid;
        logic          active;
        logic          showIds;
        logic [31:0]   sumA;
        logic [31:0]   sumB;
        logic [AW:0]   loadPtr;
        logic [15:0]   version;
        logic          fetchWait;
        logic [1:0]    pendMode;
        logic          rx;
        logic          tx;
        logic [11:0]   pendRef;
        logic [11:0]   pendLoop;
        logic [11:0]   pendAux;
        logic [11:0]   pendAdc;
        logic [11:0]   divRef;
        logic [11:0]   divLoop;
        logic [11:0]   divAux;
        logic [11:0]   divAdc;
        logic [LW-1:0] tick;
    } port_state_t;

    port_state_t q;
    port_state_t d;

    logic          csActS;
    logic          csS;
    logic          sclkS;
    logic          dataS;
    logic [1:0]    bootS;
    logic          memWrEn;
    logic [AW-1:0] memWrAddr;
    logic [15:0]   memRdData;
    logic          csFall;
    logic          csRise;
    logic          sclkRise;
    logic          sclkFall;
    logic [15:0]   wrData;
    logic [1:0]    evSet;

    pin_sync #(.WIDTH(5)) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        // select goes in inverted so the cleared stages read as deselected, no false edge
        .pinIn   ({~chipSelectLow, serialClock, commandSerialIn, bootSourceSelect}),
        .pinSync ({csActS, sclkS, dataS, bootS})
    );

    image_store #(.WIDTH(16), .DEPTH(host_port_pkg::IMAGE_WORDS), .AW(AW)) u_store (
        .clk    (clk),
        .rst_b  (rst_b),
        .wrEn   (memWrEn),
        .wrAddr (memWrAddr),
        .wrData (q.rxShift),
        .rdAddr (AW'(host_port_pkg::VERSION_INDEX)),
        .rdData (memRdData)
    );

    // data bytes carried by each command
    function automatic logic [1:0] byteCount(input logic [7:0] a);
        byteCount = (a == host_port_pkg::ADDR_GENERAL_RESET ||
                     a == host_port_pkg::ADDR_LOAD_DONE) ? 2'd1 : 2'd2;
    endfunction

    function automatic logic isReadAddr(input logic [7:0] a);
        isReadAddr = a inside {host_port_pkg::ADDR_CHECKSUM_A_HIGH,
            host_port_pkg::ADDR_CHECKSUM_A_LOW, host_port_pkg::ADDR_CHECKSUM_B_HIGH,
            host_port_pkg::ADDR_CHECKSUM_B_LOW, host_port_pkg::ADDR_PRODUCT_ID,
            host_port_pkg::ADDR_DEVICE_STATUS, host_port_pkg::ADDR_IMAGE_VERSION};
    endfunction

    function automatic logic [15:0] readValue(input logic [7:0] a);
        logic [15:0] ids;
        ids = '0;
        case (a)
            host_port_pkg::ADDR_CHECKSUM_A_HIGH: ids = q.sumA[31:16];
            host_port_pkg::ADDR_CHECKSUM_A_LOW:  ids = q.sumA[15:0];
            host_port_pkg::ADDR_CHECKSUM_B_HIGH: ids = q.sumB[31:16];
            host_port_pkg::ADDR_CHECKSUM_B_LOW:  ids = q.sumB[15:0];
            host_port_pkg::ADDR_PRODUCT_ID:      ids = PRODUCT_ID;
            host_port_pkg::ADDR_IMAGE_VERSION:   ids = q.version;
            default:                             ids = '0;
        endcase
        if (a == host_port_pkg::ADDR_DEVICE_STATUS)
            readValue = {6'h00, q.events, 7'h00, q.ready};
        else if (q.state == host_port_pkg::LOCKED && a == host_port_pkg::ADDR_CHECKSUM_A_HIGH)
            readValue = host_port_pkg::LOCKED_MARK;
        else
            readValue = q.showIds ? ids : 16'h0000;
    endfunction

    assign csS      = ~csActS;
    assign csFall   = !csS && q.csPrev;
    assign csRise   = csS && !q.csPrev;
    assign sclkRise = sclkS && !q.sclkPrev && !csS;
    assign sclkFall = !sclkS && q.sclkPrev && !csS;
    assign memWrAddr = q.loadPtr[AW-1:0];
    assign wrData   = (q.nBytes == 2'd2) ? q.rxShift : {8'h00, q.rxShift[7:0]};

    always_comb
    begin
        d = q;
        memWrEn = 1'b0;
        evSet = 2'b00;
        d.csPrev = csS;
        d.sclkPrev = sclkS;
        d.irqOut = 1'b0;

        // mode register is picked up once per latency period
        d.tick = (q.tick == TICK_LAST) ? '0 : LW'(q.tick + 1'b1);
        if (q.tick == TICK_LAST)
        begin
            d.rx = q.pendMode[0];
            d.tx = q.pendMode[1];
            if (q.pendMode != 2'b00 && !q.rx && !q.tx)
            begin
                d.divRef  = q.pendRef;
                d.divLoop = q.pendLoop;
                d.divAux  = q.pendAux;
                d.divAdc  = q.pendAdc;
            end
        end

        // serial shifter: idle clock level does not matter, a fall only
        // advances the reply after a rise has consumed the current bit
        if (csFall)
        begin
            d.bitCnt = '0;
            d.byteCnt = '0;
            d.inData = 1'b0;
            d.isRead = 1'b0;
            d.txPend = 1'b0;
        end
        else if (sclkRise)
        begin
            d.rxShift = {q.rxShift[14:0], dataS};
            d.bitCnt = 3'(q.bitCnt + 1'b1);
            d.txPend = 1'b1;
            if (q.bitCnt == 3'd7)
            begin
                if (!q.inData)
                begin
                    d.addr = {q.rxShift[6:0], dataS};
                    d.inData = 1'b1;
                    d.nBytes = byteCount(d.addr);
                    d.isRead = isReadAddr(d.addr);
                    // bit 15 waits for the next fall, pin never moves while clock high
                    d.txShift = readValue(d.addr);
                end
                else if (q.byteCnt != 2'd3)
                    d.byteCnt = 2'(q.byteCnt + 1'b1);
            end
        end
        else if (sclkFall && q.txPend && q.inData && q.isRead)
        begin
            d.txShift = {q.txShift[14:0], 1'b0};
            d.replyBit = q.txShift[15];
            d.txPend = 1'b0;
        end
        d.replyOe = !csS && d.inData && d.isRead;

        // boot sequencing
        case (q.state)
            host_port_pkg::BOOT_SAMPLE:
            begin
                d.settle = 2'(q.settle + 1'b1);
                if (q.settle == SETTLE_LAST)
                begin
                    d.settle = '0;
                    if (bootS == host_port_pkg::BOOT_HOST_LOAD)
                    begin
                        d.state = host_port_pkg::LOADING;
                        d.loadPtr = '0;
                        d.sumA = '0;
                        d.sumB = '0;
                    end
                    else if (bootS == host_port_pkg::BOOT_NO_LOAD && q.imageValid)
                        d.state = host_port_pkg::FETCH_VERSION;
                    else
                        d.state = host_port_pkg::NO_IMAGE;
                end
            end
            host_port_pkg::FETCH_VERSION:
            begin
                d.fetchWait = !q.fetchWait;
                if (q.fetchWait)
                begin
                    d.version = memRdData;
                    d.showIds = 1'b1;
                    d.ready = 1'b1;
                    d.imageValid = 1'b1;
                    d.state = host_port_pkg::IMAGE_READY;
                    evSet[host_port_pkg::EVENT_READY] = 1'b1;
                end
            end
            default:
            begin
            end
        endcase

        // command execution at the end of a transaction
        if (csRise && q.inData && !q.isRead && q.byteCnt == q.nBytes && q.bitCnt == 3'd0 &&
            q.state != host_port_pkg::LOCKED)
        begin
            case (q.addr)
                host_port_pkg::ADDR_GENERAL_RESET:
                begin
                    d.state = host_port_pkg::BOOT_SAMPLE;
                    d.settle = '0;
                    d.fetchWait = 1'b0;
                    d.mask = host_port_pkg::MASK_RESET;
                    d.events = '0;
                    d.ready = 1'b0;
                    d.showIds = 1'b0;
                    d.pendMode = '0;
                    d.rx = 1'b0;
                    d.tx = 1'b0;
                end
                host_port_pkg::ADDR_INTERRUPT_MASK: d.mask = wrData;
                host_port_pkg::ADDR_IMAGE_DATA:
                begin
                    if (q.state == host_port_pkg::LOADING)
                    begin
                        if (q.loadPtr == PTR_FULL)
                            evSet[host_port_pkg::EVENT_OVERFLOW] = 1'b1;
                        else
                        begin
                            memWrEn = 1'b1;
                            d.loadPtr = (AW+1)'(q.loadPtr + 1'b1);
                            d.sumA = q.sumA + {16'h0000, wrData};
                            d.sumB = {q.sumB[30:0], q.sumB[31]} ^ {16'h0000, wrData};
                        end
                    end
                end
                host_port_pkg::ADDR_LOAD_DONE:
                    if (q.state == host_port_pkg::LOADING)
                        d.state = host_port_pkg::FETCH_VERSION;
                host_port_pkg::ADDR_ACTIVATE:
                begin
                    if (q.state == host_port_pkg::IMAGE_READY)
                    begin
                        d.showIds = 1'b0;
                        if (wrData == ACTIVATION_CODE)
                            d.state = host_port_pkg::ACTIVE;
                        else
                            d.state = host_port_pkg::LOCKED;
                    end
                end
                host_port_pkg::ADDR_MODE:
                    if (q.state == host_port_pkg::ACTIVE)
                        d.pendMode = wrData[1:0];
                host_port_pkg::ADDR_DIVIDER:
                begin
                    if (q.state == host_port_pkg::ACTIVE)
                    begin
                        case (wrData[15:host_port_pkg::DIV_INDEX_LSB])
                            host_port_pkg::DIV_INDEX_REF:  d.pendRef  = wrData[11:0];
                            host_port_pkg::DIV_INDEX_LOOP: d.pendLoop = wrData[11:0];
                            host_port_pkg::DIV_INDEX_AUX:  d.pendAux  = wrData[11:0];
                            host_port_pkg::DIV_INDEX_ADC:  d.pendAdc  = wrData[11:0];
                            default:
                            begin
                            end
                        endcase
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (csRise && q.inData && q.isRead && q.byteCnt == q.nBytes &&
                 q.addr == host_port_pkg::ADDR_DEVICE_STATUS)
            d.events = '0;

        // a new event in the clearing cycle survives
        d.events = d.events | evSet;
        d.irqOe = |(d.events & d.mask[host_port_pkg::STATUS_EVENT_LSB +: 2]);
        d.active = (d.state == host_port_pkg::ACTIVE);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.state <= host_port_pkg::BOOT_SAMPLE;
            q.csPrev <= 1'b1;
            q.mask <= host_port_pkg::MASK_RESET;
            q.pendRef <= host_port_pkg::DIV_REF_RESET;
            q.pendLoop <= host_port_pkg::DIV_LOOP_RESET;
            q.pendAux <= host_port_pkg::DIV_AUX_RESET;
            q.pendAdc <= host_port_pkg::DIV_ADC_RESET;
            q.divRef <= host_port_pkg::DIV_REF_RESET;
            q.divLoop <= host_port_pkg::DIV_LOOP_RESET;
            q.divAux <= host_port_pkg::DIV_AUX_RESET;
            q.divAdc <= host_port_pkg::DIV_ADC_RESET;
        end
        else
            q <= d;
    end

    assign replyData = q.replyBit;
    assign replyDataOe = q.replyOe;
    assign hostInterruptLowOut = q.irqOut;
    assign hostInterruptLowOe = q.irqOe;
    assign rxActive = q.rx;
    assign txActive = q.tx;
    assign imageActive = q.active;
    assign refDivide = q.divRef;
    assign loopDivide = q.divLoop;
    assign auxDivide = q.divAux;
    assign adcDivide = q.divAdc;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence csEnds;
        !q.csPrev ##1 csS;
    endsequence

    chk_irq_masked: assert property (hostInterruptLowOe |->
        |(q.events & q.mask[host_port_pkg::STATUS_EVENT_LSB +: 2]))
        else $error("interrupt driven without masked-in event");
    chk_status_release: assert property (csRise && q.inData && q.isRead &&
        q.addr == host_port_pkg::ADDR_DEVICE_STATUS && q.byteCnt == 2'd2 && evSet == 2'b00
        |=> !hostInterruptLowOe)
        else $error("interrupt not released after status read");
    chk_sample_rise: assert property (sclkRise |=> q.rxShift[0] == $past(dataS))
        else $error("command bit not sampled on clock rise");
    chk_reply_stable: assert property (replyDataOe && sclkS && q.sclkPrev && !csS
        |-> $stable(replyData))
        else $error("reply bit moved while clock high");
    chk_exec_on_cs: assert property (!$stable(q.mask) |-> $past(csS && !q.csPrev))
        else $error("mask changed outside chip select rise");
    chk_reply_cs: assert property (replyDataOe |-> $past(!csS))
        else $error("reply driven while deselected");
    chk_locked_sticky: assert property (csEnds ##0 q.state == host_port_pkg::LOCKED
        |=> q.state == host_port_pkg::LOCKED)
        else $error("locked device responded");
    chk_ids_cleared: assert property (q.state == host_port_pkg::ACTIVE |-> !q.showIds)
        else $error("identity readable after activation");
    chk_mode_tick: assert property (!$stable(rxActive) |-> $past(q.tick) == TICK_LAST)
        else $error("mode moved outside latency tick");
    chk_div_apply: assert property (!$stable(refDivide) |->
        $past(!q.rx && !q.tx) && (rxActive || txActive))
        else $error("divider applied without entering rx or tx");
endmodule

// [verilog/host_port_pkg.sv]
// constants shared by the serial host port and image boot logic
package host_port_pkg;
    // timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int LATENCY_NS         = 250000;
    localparam int LATENCY_CYCLES     = LATENCY_NS / CLK_PERIOD_NS;
    localparam int BOOT_SETTLE_CYCLES = 3;
    // image store
    localparam int IMAGE_BYTES   = 46 * 1024;
    localparam int IMAGE_WORDS   = IMAGE_BYTES / 2;
    localparam int VERSION_INDEX = 0;
    // register addresses
    localparam logic [7:0] ADDR_GENERAL_RESET   = 8'h01;
    localparam logic [7:0] ADDR_CHECKSUM_A_HIGH = 8'ha9;
    localparam logic [7:0] ADDR_CHECKSUM_A_LOW  = 8'haa;
    localparam logic [7:0] ADDR_CHECKSUM_B_HIGH = 8'hb8;
    localparam logic [7:0] ADDR_CHECKSUM_B_LOW  = 8'hb9;
    localparam logic [7:0] ADDR_MODE            = 8'hc1;
    localparam logic [7:0] ADDR_PRODUCT_ID      = 8'hc5;
    localparam logic [7:0] ADDR_DEVICE_STATUS   = 8'hc6;
    localparam logic [7:0] ADDR_IMAGE_DATA      = 8'hc7;
    localparam logic [7:0] ADDR_IMAGE_VERSION   = 8'hc9;
    localparam logic [7:0] ADDR_ACTIVATE        = 8'hca;
    localparam logic [7:0] ADDR_LOAD_DONE       = 8'hcb;
    localparam logic [7:0] ADDR_INTERRUPT_MASK  = 8'hce;
    localparam logic [7:0] ADDR_DIVIDER         = 8'hcf;
    // field positions
    localparam int STATUS_READY_BIT    = 0;
    localparam int STATUS_EVENT_LSB    = 8;
    localparam int EVENT_READY         = 0;
    localparam int EVENT_OVERFLOW      = 1;
    localparam int DIV_INDEX_LSB       = 12;
    localparam logic [3:0] DIV_INDEX_REF  = 4'h4;
    localparam logic [3:0] DIV_INDEX_LOOP = 4'h5;
    localparam logic [3:0] DIV_INDEX_AUX  = 4'h6;
    localparam logic [3:0] DIV_INDEX_ADC  = 4'h7;
    // reset and report values
    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [11:0] DIV_REF_RESET  = 12'h020;
    localparam logic [11:0] DIV_LOOP_RESET = 12'h200;
    localparam logic [11:0] DIV_AUX_RESET  = 12'h140;
    localparam logic [11:0] DIV_ADC_RESET  = 12'h008;
    localparam logic [15:0] LOCKED_MARK    = 16'hdead;
    localparam logic [1:0]  BOOT_HOST_LOAD = 2'b11;
    localparam logic [1:0]  BOOT_NO_LOAD   = 2'b00;

    typedef enum logic [2:0] {
        BOOT_SAMPLE   = 3'b000,
        LOADING       = 3'b001,
        FETCH_VERSION = 3'b011,
        IMAGE_READY   = 3'b010,
        ACTIVE        = 3'b110,
        LOCKED        = 3'b111,
        NO_IMAGE      = 3'b100
    } boot_state_t;
endpackage

// [verilog/pin_sync.sv]
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // pins and synchronised levels
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb
    begin
        d.stage1 = pinIn;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    assign pinSync = q.stage2;
endmodule

// [verilog/image_store.sv]
// single-port-write, registered-read store for the configuration image
`timescale 1ns/1ns
module image_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = host_port_pkg::IMAGE_WORDS,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // write side
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    // read side, data one cycle after the address
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    // array holds no reset so it maps to block memory
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdData <= '0;
        else
            rdData <= mem[rdAddr];
    end
endmodule

// [tb/host_model.sv]
// host microcontroller model driving the serial control bus
`timescale 1ns/1ns
module host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      chipSelectLow,
    output logic      serialClock,
    output logic      commandSerialIn,
    input  wire logic replyData,
    input  wire logic replyDataOe
);
    logic lastR = 1'b0;
    // released line shows the inverse of its last bit
    wire  rLine = replyDataOe ? replyData : ~lastR;
    always @(posedge clk)
        if (replyDataOe)
            lastR <= replyData;
    initial
    begin
        chipSelectLow = 1'b1;
        serialClock = 1'b0;
        commandSerialIn = 1'b0;
    end
    // address byte then nb data bytes, msb first
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int nb,
                        input logic idle, output logic [15:0] rd);
        logic [23:0] sh;
        sh = (nb == 1) ? {a, d[7:0], 8'h00} : {a, d};
        rd = 16'h0000;
        @(posedge clk);
        serialClock <= idle;
        chipSelectLow <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 8 + 8 * nb; i++)
        begin
            serialClock <= 1'b0;
            commandSerialIn <= sh[23 - i];
            repeat (5) @(posedge clk);
            serialClock <= 1'b1;
            repeat (5) @(posedge clk);
            rd = {rd[14:0], rLine};
        end
        serialClock <= idle;
        repeat (5) @(posedge clk);
        chipSelectLow <= 1'b1;
        repeat (120) @(posedge clk);
    endtask
endmodule

// [tb/serial_host_port_image_boot_test.sv]
// self-checking bench for the serial host port and image boot
`timescale 1ns/1ns
module serial_host_port_image_boot_test;
    logic        clk, rst_b, csL, sck, sdi, rD, rOe, iOut, iOe, rx, tx, act;
    logic [1:0]  boot;
    logic [11:0] dRef, dLoop, dAux, dAdc;
    logic [15:0] rd, w, v;
    logic [31:0] seed, sa, sb;
    logic [7:0]  ad [6];
    logic [15:0] ex [6];
    int          miscompares, compares;
    wire         iLine = iOe ? iOut : 1'b1;
    serial_host_port_image_boot #(.LATENCY_CYCLES(16)) i_serial_host_port_image_boot (
        .clk(clk), .rst_b(rst_b), .chipSelectLow(csL), .serialClock(sck),
        .commandSerialIn(sdi), .replyData(rD), .replyDataOe(rOe),
        .hostInterruptLowIn(iLine), .hostInterruptLowOut(iOut), .hostInterruptLowOe(iOe),
        .bootSourceSelect(boot), .rxActive(rx), .txActive(tx), .imageActive(act),
        .refDivide(dRef), .loopDivide(dLoop), .auxDivide(dAux), .adcDivide(dAdc));
    host_model i_host_model (.clk(clk), .chipSelectLow(csL), .serialClock(sck),
        .commandSerialIn(sdi), .replyData(rD), .replyDataOe(rOe));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic bus(input logic [7:0] a, input logic [15:0] d, input int n);
        seed = xs(seed);
        i_host_model.xfer(a, d, n, seed[16], rd);
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #500000;
        miscompares++;
        results();
    end
    initial
    begin
        {seed, sa, sb, miscompares, compares} = {32'he468, 64'h0, 64'h0};
        rst_b = 1'b0;
        boot = 2'b11;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        cmp("refDiv", 16'h0020, {4'h0, dRef});
        cmp("loopDiv", 16'h0200, {4'h0, dLoop});
        cmp("auxDiv", 16'h0140, {4'h0, dAux});
        cmp("adcDiv", 16'h0008, {4'h0, dAdc});
        repeat (10) @(posedge clk);
        bus(host_port_pkg::ADDR_INTERRUPT_MASK, 16'h0100, 2);
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            w = seed[15:0];
            if (i == 0)
                v = w;
            sa += w;
            sb = {sb[30:0], sb[31]} ^ w;
            bus(host_port_pkg::ADDR_IMAGE_DATA, w, 2);
        end
        cmp("irqBefore", 16'h0, {15'h0, iOe});
        bus(host_port_pkg::ADDR_LOAD_DONE, 16'h0, 1);
        cmp("irqPin", 16'h0, {15'h0, iLine});
        bus(host_port_pkg::ADDR_DEVICE_STATUS, 16'h0, 2);
        cmp("status", 16'h0101, rd);
        cmp("irqCleared", 16'h0, {15'h0, iOe});
        ad = '{8'hc5, 8'hc9, 8'ha9, 8'haa, 8'hb8, 8'hb9};
        ex = '{16'h0a5c, v, sa[31:16], sa[15:0], sb[31:16], sb[15:0]};
        for (int i = 0; i < 6; i++)
        begin
            bus(ad[i], 16'h0, 2);
            cmp("report", ex[i], rd);
        end
        $display("test image load done");
        boot <= 2'b00;
        bus(host_port_pkg::ADDR_GENERAL_RESET, 16'h0, 1);
        bus(host_port_pkg::ADDR_DEVICE_STATUS, 16'h0, 2);
        cmp("keptImage", 16'h0101, rd);
        bus(host_port_pkg::ADDR_ACTIVATE, 16'h3c96, 2);
        cmp("active", 16'h1, {15'h0, act});
        bus(8'hc9, 16'h0, 2);
        cmp("clearedVer", 16'h0, rd);
        seed = xs(seed);
        w = {4'h4, seed[11:0]};
        bus(host_port_pkg::ADDR_DIVIDER, w, 2);
        cmp("refHeld", 16'h0020, {4'h0, dRef});
        bus(host_port_pkg::ADDR_MODE, 16'h0001, 2);
        cmp("modeRx", 16'h0001, {14'h0, tx, rx});
        cmp("refNew", {4'h0, w[11:0]}, {4'h0, dRef});
        $display("test activation done");
        boot <= 2'b11;
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        cmp("refReset", 16'h0020, {4'h0, dRef});
        bus(host_port_pkg::ADDR_IMAGE_DATA, w, 2);
        bus(host_port_pkg::ADDR_LOAD_DONE, 16'h0, 1);
        bus(host_port_pkg::ADDR_ACTIVATE, 16'h0000, 2);
        bus(host_port_pkg::ADDR_GENERAL_RESET, 16'h0, 1);
        bus(8'ha9, 16'h0, 2);
        cmp("lockedMark", 16'hdead, rd);
        bus(8'hc5, 16'h0, 2);
        cmp("lockedId", 16'h0000, rd);
        cmp("replyOff", 16'h0, {15'h0, rOe});
        cmp("lockedAct", 16'h0, {15'h0, act});
        $display("test lockup done");
        results();
    end
endmodule
